// ### src/bmf_fifo.sv
// 36-bit fifo, write port to read port, with read-side bus matching
// assumes both ports share i_core_clk; thresholds and selects are steady
`timescale 1ns/10ps
`default_nettype none

module bmf_fifo (
    input  wire logic                              i_core_clk,
    input  wire logic                              i_resetn,
    // mode straps
    input  wire logic                              i_order_or_timing_select,
    input  wire logic                              i_narrow_width_select,
    input  wire logic                              i_byte_width_choice,
    // flag thresholds
    input  wire logic [bmf_pkg::BMF_PTR_W-1:0]     i_empty_threshold,
    input  wire logic [bmf_pkg::BMF_PTR_W-1:0]     i_full_threshold,
    // write port
    input  wire logic                              i_write_port_select_n,
    input  wire logic                              i_write_port_qualifier,
    input  wire logic                              i_write_port_dir_write,
    input  wire logic [bmf_pkg::BMF_DATA_W-1:0]    i_write_port_bus,
    output var  logic [bmf_pkg::BMF_DATA_W-1:0]    o_write_port_bus,
    output logic                                   o_write_port_bus_oe,
    output var  logic                              o_write_side_status,
    output var  logic                              o_almost_full_n,
    // read port
    input  wire logic                              i_read_port_select_n,
    input  wire logic                              i_read_port_qualifier,
    input  wire logic                              i_read_port_dir_read,
    input  wire logic [bmf_pkg::BMF_DATA_W-1:0]    i_read_port_bus,
    output var  logic [bmf_pkg::BMF_DATA_W-1:0]    o_read_port_bus,
    output logic                                   o_read_port_bus_oe,
    output var  logic                              o_read_side_status,
    output var  logic                              o_almost_empty_n,
    // latched byte order and registered timing mode
    output var  logic                              o_msb_first_order,
    output var  logic                              o_fall_through_mode
);
    import bmf_pkg::*;

    typedef enum logic [2:0] {
        BMF_ST_RESET = 3'h1,
        BMF_ST_STRAP = 3'h2,
        BMF_ST_RUN   = 3'h4
    } bmf_state_t;

    bmf_state_t                state;
    bmf_state_t                next_state;

    logic [BMF_DATA_W-1:0]     mem [0:BMF_DEPTH-1];

    bmf_ptr_t                  wr_ptr;
    bmf_ptr_t                  rd_ptr;
    bmf_ptr_t                  wr_ptr_at_rd;
    bmf_ptr_t                  rd_ptr_at_wr;
    bmf_ptr_t                  wr_used;
    bmf_ptr_t                  wr_free;
    bmf_ptr_t                  rd_stored;
    bmf_ptr_t                  rd_total;

    logic                      msb_first_order;
    logic                      fall_through_mode;
    logic                      narrow_width_select;
    logic                      byte_width_choice;
    logic                      running;
    logic                      full;
    logic                      wr_strobe;
    logic                      wr_take;
    logic                      rd_strobe;
    logic                      rd_take;
    logic                      mem_has_word;

    logic [BMF_DATA_W-1:0]     stage_word;
    logic                      stage_valid;
    logic [BMF_IDX_W-1:0]      stage_idx;
    logic [BMF_DATA_W-1:0]     next_stage_word;
    logic                      next_stage_valid;
    logic [BMF_IDX_W-1:0]      next_stage_idx;
    logic                      refill;
    logic                      last_part;
    logic [BMF_IDX_W-1:0]      last_idx;
    logic [BMF_DATA_W-1:0]     out_word;
    logic [BMF_DATA_W-1:0]     next_out_word;

    // pick one part of a stored word for the read bus
    function automatic logic [BMF_DATA_W-1:0] bmf_part(
        input logic [BMF_DATA_W-1:0] w,
        input logic [BMF_IDX_W-1:0]  idx,
        input logic                  narrow,
        input logic                  byte_w,
        input logic                  msb_first
    );
        logic [BMF_IDX_W-1:0]  slot;
        logic [BMF_DATA_W-1:0] r;
        slot = idx;
        r    = w;
        if (!narrow) begin
            r = w;
        end else if (byte_w) begin
            slot = msb_first ? BMF_LAST_BYTE - idx : idx;
            r    = {27'h0000000, w[slot*BMF_BYTE_W +: BMF_BYTE_W]};
        end else begin
            slot = msb_first ? BMF_LAST_WORD - idx : idx;
            r    = {18'h00000, w[slot*BMF_WORD_W +: BMF_WORD_W]};
        end
        return r;
    endfunction

    // index of the last part for the chosen width
    function automatic logic [BMF_IDX_W-1:0] bmf_last(
        input logic narrow,
        input logic byte_w
    );
        logic [BMF_IDX_W-1:0] r;
        r = BMF_LAST_LONG;
        if (narrow) begin
            r = byte_w ? BMF_LAST_BYTE : BMF_LAST_WORD;
        end
        return r;
    endfunction

    // reset release sequence
    always_comb begin
        next_state = state;
        case (state)
            BMF_ST_RESET: begin
                next_state = BMF_ST_STRAP;
            end
            BMF_ST_STRAP: begin
                next_state = BMF_ST_RUN;
            end
            BMF_ST_RUN: begin
                next_state = BMF_ST_RUN;
            end
            default: begin
                next_state = BMF_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= BMF_ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign running = (state == BMF_ST_RUN);

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            msb_first_order <= 1'b0;
        end else if (state == BMF_ST_RESET) begin
            msb_first_order <= i_order_or_timing_select;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            fall_through_mode <= 1'b0;
        end else if (state != BMF_ST_RESET) begin
            fall_through_mode <= ~i_order_or_timing_select;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            narrow_width_select <= 1'b0;
        end else if (state == BMF_ST_RESET) begin
            narrow_width_select <= i_narrow_width_select;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            byte_width_choice <= 1'b0;
        end else if (state == BMF_ST_RESET) begin
            byte_width_choice <= i_byte_width_choice;
        end
    end

    assign o_msb_first_order   = msb_first_order;
    assign o_fall_through_mode = fall_through_mode;

    bmf_ptr_sync u_wr_to_rd (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_ptr      (wr_ptr),
        .o_ptr      (wr_ptr_at_rd)
    );

    bmf_ptr_sync u_rd_to_wr (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_ptr      (rd_ptr),
        .o_ptr      (rd_ptr_at_wr)
    );

    // write side counts
    assign wr_used = wr_ptr - rd_ptr_at_wr;
    assign wr_free = BMF_DEPTH - wr_used;
    assign full    = (wr_used == BMF_DEPTH);

    assign wr_strobe = ~i_write_port_select_n & i_write_port_qualifier;
    assign wr_take   = wr_strobe & i_write_port_dir_write & ~full & running;

    always_ff @(posedge i_core_clk) begin
        if (wr_take) begin
            mem[wr_ptr[BMF_ADDR_W-1:0]] <= i_write_port_bus;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ptr <= BMF_PTR_RST;
        end else if (wr_take) begin
            wr_ptr <= wr_ptr + 12'h001;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_write_side_status <= 1'b0;
        end else begin
            o_write_side_status <= running & ~(wr_used + {11'h000, wr_take} == BMF_DEPTH);
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_almost_full_n <= 1'b1;
        end else begin
            o_almost_full_n <= ~(wr_free - {11'h000, wr_take} <= i_full_threshold);
        end
    end

    assign o_write_port_bus    = BMF_DATA_RST;
    assign o_write_port_bus_oe = ~i_write_port_select_n & ~i_write_port_dir_write;

    // read side counts
    assign rd_stored    = wr_ptr_at_rd - rd_ptr;
    assign mem_has_word = (rd_stored != BMF_PTR_RST);
    assign rd_total     = rd_stored + {11'h000, stage_valid};

    assign rd_strobe = ~i_read_port_select_n & i_read_port_qualifier;
    assign rd_take   = rd_strobe & i_read_port_dir_read & stage_valid;

    assign last_idx  = bmf_last(narrow_width_select, byte_width_choice);
    assign last_part = (stage_idx == last_idx);
    assign refill    = mem_has_word & (~stage_valid | (rd_take & last_part));

    always_comb begin
        next_stage_word  = stage_word;
        next_stage_valid = stage_valid;
        next_stage_idx   = stage_idx;
        if (refill) begin
            next_stage_word  = mem[rd_ptr[BMF_ADDR_W-1:0]];
            next_stage_valid = 1'b1;
            next_stage_idx   = BMF_IDX_RST;
        end else if (rd_take && last_part) begin
            next_stage_valid = 1'b0;
            next_stage_idx   = BMF_IDX_RST;
        end else if (rd_take) begin
            next_stage_idx   = stage_idx + 2'h1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            stage_word  <= BMF_DATA_RST;
            stage_valid <= 1'b0;
            stage_idx   <= BMF_IDX_RST;
        end else begin
            stage_word  <= next_stage_word;
            stage_valid <= next_stage_valid;
            stage_idx   <= next_stage_idx;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_ptr <= BMF_PTR_RST;
        end else if (refill) begin
            rd_ptr <= rd_ptr + 12'h001;
        end
    end

    always_comb begin
        next_out_word = out_word;
        if (fall_through_mode) begin
            next_out_word = bmf_part(next_stage_word, next_stage_idx,
                                     narrow_width_select, byte_width_choice,
                                     msb_first_order);
        end else if (rd_take) begin
            next_out_word = bmf_part(stage_word, stage_idx,
                                     narrow_width_select, byte_width_choice,
                                     msb_first_order);
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            out_word <= BMF_DATA_RST;
        end else begin
            out_word <= next_out_word;
        end
    end

    assign o_read_port_bus    = out_word;
    assign o_read_port_bus_oe = ~i_read_port_select_n & i_read_port_dir_read;

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_read_side_status <= 1'b0;
        end else begin
            o_read_side_status <= next_stage_valid;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_almost_empty_n <= 1'b0;
        end else begin
            o_almost_empty_n <= ~(rd_total <= i_empty_threshold);
        end
    end

    // i_read_port_bus is observed only as a pin; no write path on the read port
    logic unused_read_bus;
    assign unused_read_bus = ^i_read_port_bus;

endmodule // bmf_fifo

`default_nettype wire

// ### common/bmf_pkg.sv
// constants, types and helper functions for the bus-matching fifo
// assumes one core clock shared by both ports
//
// Overview of operation
// - almost-empty output goes low when stored words <= empty-side threshold.
// - almost-full output goes low when free locations <= full-side threshold.
// - almost-empty output is updated only on read-side clock edges.
// - write-side status and almost-full output update on write-side clock edges.
// - write port has a 36-bit two-way data bus.
// - read port has a 36-bit two-way data bus.
// - select high during reset: most significant part read first.
// - select low during reset: least significant part read first.
// - after reset the select picks timing: high standard, low fall-through.
// - width select low gives 36-bit reads, high gives byte or word width.
// - write-port edge acts only while write-port select is low.
// - write-port bus drivers are off while write-port select is high.
// - read-port edge acts only while read-port select is low.
// - read-port bus drivers are off while read-port select is high.
// - standard timing: read-side status is the not-empty flag.
// - fall-through timing: read-side status means valid data on the bus.
// - read-side status changes only on read-side clock edges.
// - both ports run on the one core clock; the logic has no separate port clocks.
// - write-port edge transfers data only while its qualifier is high.
// - read-port edge transfers data only while its qualifier is high.
// - write-side status is full flag or input-ready, by timing mode; the code gives the same not-full flag in both modes.

package bmf_pkg;

    localparam int unsigned BMF_DATA_W  = 36;
    localparam int unsigned BMF_ADDR_W  = 11;
    localparam int unsigned BMF_PTR_W   = 12;
    localparam int unsigned BMF_WORD_W  = 18;
    localparam int unsigned BMF_BYTE_W  = 9;
    localparam int unsigned BMF_IDX_W   = 2;

    localparam logic [BMF_PTR_W-1:0]  BMF_DEPTH     = 12'h800;
    localparam logic [BMF_DATA_W-1:0] BMF_DATA_RST  = 36'h000000000;
    localparam logic [BMF_PTR_W-1:0]  BMF_PTR_RST   = 12'h000;
    localparam logic [BMF_IDX_W-1:0]  BMF_IDX_RST   = 2'h0;
    localparam logic [BMF_IDX_W-1:0]  BMF_LAST_LONG = 2'h0;
    localparam logic [BMF_IDX_W-1:0]  BMF_LAST_WORD = 2'h1;
    localparam logic [BMF_IDX_W-1:0]  BMF_LAST_BYTE = 2'h3;

    typedef logic [BMF_PTR_W-1:0] bmf_ptr_t;

    // binary to gray
    function automatic bmf_ptr_t bmf_to_gray(input bmf_ptr_t b);
        return b ^ (b >> 1);
    endfunction

    // gray to binary
    function automatic bmf_ptr_t bmf_from_gray(input bmf_ptr_t g);
        bmf_ptr_t b;
        b = g;
        for (int i = BMF_PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

endpackage : bmf_pkg

// ### src/bmf_ptr_sync.sv
// two-stage gray-coded pointer synchroniser
// assumes the pointer moves by at most one per clock
`timescale 1ns/10ps
`default_nettype none

module bmf_ptr_sync (
    input  wire logic              i_core_clk,
    input  wire logic              i_resetn,
    input  wire bmf_pkg::bmf_ptr_t i_ptr,
    output var  bmf_pkg::bmf_ptr_t o_ptr
);
    import bmf_pkg::*;

    bmf_ptr_t gray_src;
    bmf_ptr_t gray_s1;
    bmf_ptr_t gray_s2;

    // launch register in gray code
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            gray_src <= BMF_PTR_RST;
        end else begin
            gray_src <= bmf_to_gray(i_ptr);
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            gray_s1 <= BMF_PTR_RST;
            gray_s2 <= BMF_PTR_RST;
        end else begin
            gray_s1 <= gray_src;
            gray_s2 <= gray_s1;
        end
    end

    assign o_ptr = bmf_from_gray(gray_s2);

endmodule // bmf_ptr_sync

`default_nettype wire

// ### verification/bmf_fifo_props.sv
// port checker for the bus-matching fifo
// bound to bmf_fifo; one clock, async active-low reset
`timescale 1ns/10ps
`default_nettype none
module bmf_fifo_props import bmf_pkg::*; (
    input wire logic                  i_core_clk,
    input wire logic                  i_resetn,
    input wire logic                  i_order_or_timing_select,
    input wire logic                  i_write_port_select_n,
    input wire logic                  i_write_port_qualifier,
    input wire logic                  i_write_port_dir_write,
    input wire logic                  i_read_port_select_n,
    input wire logic                  i_read_port_qualifier,
    input wire logic                  i_read_port_dir_read,
    input wire logic                  o_write_port_bus_oe,
    input wire logic                  o_read_port_bus_oe,
    input wire logic [BMF_DATA_W-1:0] o_read_port_bus,
    input wire logic                  o_read_side_status,
    input wire logic                  o_write_side_status,
    input wire logic                  o_almost_full_n,
    input wire logic                  o_msb_first_order,
    input wire logic                  o_fall_through_mode
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    logic wr_go;
    logic rd_go;
    assign wr_go = !i_write_port_select_n && i_write_port_qualifier && i_write_port_dir_write;
    assign rd_go = !i_read_port_select_n && i_read_port_qualifier && i_read_port_dir_read;
    property p_wr_oe;
        o_write_port_bus_oe == (!i_write_port_select_n && !i_write_port_dir_write);
    endproperty
    a_wr_oe: assert property (p_wr_oe) else $error("write bus drive wrong");
    property p_rd_oe;
        o_read_port_bus_oe == (!i_read_port_select_n && i_read_port_dir_read);
    endproperty
    a_rd_oe: assert property (p_rd_oe) else $error("read bus drive wrong");
    property p_rd_desel;
        !o_fall_through_mode && i_read_port_select_n |=> $stable(o_read_port_bus);
    endproperty
    a_rd_desel: assert property (p_rd_desel) else $error("read bus moved unselected");
    property p_rd_noqual;
        !o_fall_through_mode && !i_read_port_qualifier |=> $stable(o_read_port_bus);
    endproperty
    a_rd_noqual: assert property (p_rd_noqual) else $error("read bus moved unqualified");
    property p_empty;
        $fell(o_read_side_status) |-> $past(rd_go) || $past(rd_go, 2);
    endproperty
    a_empty: assert property (p_empty) else $error("read status fell with no read");
    property p_full;
        $fell(o_write_side_status) |-> $past(wr_go) || $past(wr_go, 2);
    endproperty
    a_full: assert property (p_full) else $error("write status fell with no write");
    property p_af;
        $fell(o_almost_full_n) |-> $past(wr_go) || $past(wr_go, 2);
    endproperty
    a_af: assert property (p_af) else $error("almost full fell with no write");
    property p_mode;
        $past(i_resetn, 2) && $past(i_resetn)
            |-> o_fall_through_mode == !$past(i_order_or_timing_select);
    endproperty
    a_mode: assert property (p_mode) else $error("timing mode wrong");
    property p_endian;
        $past(i_resetn, 2) && $past(i_resetn) |-> $stable(o_msb_first_order);
    endproperty
    a_endian: assert property (p_endian) else $error("byte order moved");
endmodule // bmf_fifo_props
bind bmf_fifo bmf_fifo_props u_props (
    .i_core_clk               (i_core_clk),
    .i_resetn                 (i_resetn),
    .i_order_or_timing_select (i_order_or_timing_select),
    .i_write_port_select_n    (i_write_port_select_n),
    .i_write_port_qualifier   (i_write_port_qualifier),
    .i_write_port_dir_write   (i_write_port_dir_write),
    .i_read_port_select_n     (i_read_port_select_n),
    .i_read_port_qualifier    (i_read_port_qualifier),
    .i_read_port_dir_read     (i_read_port_dir_read),
    .o_write_port_bus_oe      (o_write_port_bus_oe),
    .o_read_port_bus_oe       (o_read_port_bus_oe),
    .o_read_port_bus          (o_read_port_bus),
    .o_read_side_status       (o_read_side_status),
    .o_write_side_status      (o_write_side_status),
    .o_almost_full_n          (o_almost_full_n),
    .o_msb_first_order        (o_msb_first_order),
    .o_fall_through_mode      (o_fall_through_mode)
);
`default_nettype wire

// ### verification/bmf_bus_end.sv
// far-side end of one 36-bit port bus: resolves the shared wire
// assumes one clock; a released bus shows the inverse of its last level
`timescale 1ns/10ps
`default_nettype none
module bmf_bus_end import bmf_pkg::*; (
    input  wire logic                  i_clk,
    input  wire logic [BMF_DATA_W-1:0] i_dev_bus,
    input  wire logic                  i_dev_oe,
    input  wire logic [BMF_DATA_W-1:0] i_own_bus,
    input  wire logic                  i_own_oe,
    output var  logic [BMF_DATA_W-1:0] o_wire
);
    logic [BMF_DATA_W-1:0] last = BMF_DATA_RST;
    always_ff @(posedge i_clk) begin
        last <= o_wire;
    end
    always_comb begin
        if (i_dev_oe) begin
            o_wire = i_dev_bus;
        end else if (i_own_oe) begin
            o_wire = i_own_bus;
        end else begin
            o_wire = ~last;
        end
    end
endmodule // bmf_bus_end
`default_nettype wire

// ### verification/bmf_fifo_tb.sv
// self-checking bench for the bus-matching fifo
// one core clock drives both ports; far ends modelled by bmf_bus_end
`timescale 1ns/10ps
`default_nettype none
module bmf_fifo_tb;
    import bmf_pkg::*;
    logic clk, resetn, sel, nar, byt, ws_n, wq, wd, rs_n, rq, rd, msb_e, ftm_e;
    logic woe, roe, wst, af_n, rst_s, ae_n, msb, ftm;
    logic [BMF_DATA_W-1:0] wdata, wwire, rwire, wbus, rbus;
    int failures = 0;
    int n_compared = 0;
    int n;
    logic [3:0] cfg [5] = '{4'hC, 4'h3, 4'hF, 4'h6, 4'hA};
    bmf_fifo uut (.i_core_clk(clk), .i_resetn(resetn), .i_order_or_timing_select(sel),
        .i_narrow_width_select(nar), .i_byte_width_choice(byt),
        .i_empty_threshold(12'h002), .i_full_threshold(12'h004),
        .i_write_port_select_n(ws_n), .i_write_port_qualifier(wq),
        .i_write_port_dir_write(wd), .i_write_port_bus(wwire), .o_write_port_bus(wbus),
        .o_write_port_bus_oe(woe), .o_write_side_status(wst), .o_almost_full_n(af_n),
        .i_read_port_select_n(rs_n), .i_read_port_qualifier(rq), .i_read_port_dir_read(rd),
        .i_read_port_bus(rwire), .o_read_port_bus(rbus), .o_read_port_bus_oe(roe),
        .o_read_side_status(rst_s), .o_almost_empty_n(ae_n),
        .o_msb_first_order(msb), .o_fall_through_mode(ftm));
    bmf_bus_end u_wend (.i_clk(clk), .i_dev_bus(wbus), .i_dev_oe(woe),
        .i_own_bus(wdata), .i_own_oe(wd), .o_wire(wwire));
    bmf_bus_end u_rend (.i_clk(clk), .i_dev_bus(rbus), .i_dev_oe(roe),
        .i_own_bus(BMF_DATA_RST), .i_own_oe(1'b0), .o_wire(rwire));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    function automatic logic [35:0] f(input int i);
        return {9'(i * 4 + 3), 9'(i * 4 + 2), 9'(i * 4 + 1), 9'(i * 4)};
    endfunction
    task automatic check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic start(input logic sr, input logic sw, input logic nw, input logic b);
        resetn = 0;
        sel = sr;
        nar = nw;
        byt = b;
        msb_e = sr;
        ftm_e = !sw;
        repeat (8) @(posedge clk);
        #1 resetn = 1;
        @(posedge clk);
        #1 sel = sw;
        repeat (2) @(posedge clk);
        #1 check("order", msb, sr);
        check("mode", ftm, !sw);
    endtask
    task automatic wr(input int cnt, input int base, input logic s, input logic q);
        @(posedge clk);
        #1 ws_n = s;
        wq = q;
        for (int i = 0; i < cnt; i++) begin
            wdata = f(base + i);
            @(posedge clk);
            #1;
        end
        ws_n = 1;
        wq = 0;
        @(posedge clk);
        #1;
    endtask
    task automatic wait_rd();
        int t;
        t = 0;
        do begin
            @(posedge clk);
            #1 t++;
        end while (rst_s !== 1'b1 && t < 30);
        if (t >= 30) check("ready", rst_s, 1'b1);
    endtask
    task automatic rd_word(input logic [35:0] w);
        int np;
        int pw;
        int idx;
        logic [35:0] e;
        np = !nar ? 1 : (byt ? 4 : 2);
        pw = !nar ? 36 : (byt ? 9 : 18);
        @(posedge clk);
        #1 rs_n = 0;
        for (int k = 0; k < np; k++) begin
            idx = msb_e ? np - 1 - k : k;
            e = (w >> (idx * pw)) & ((36'h1 << pw) - 36'h1);
            wait_rd();
            if (ftm_e) check("ft part", rwire, e);
            rq = 1;
            @(posedge clk);
            #1 rq = 0;
            if (!ftm_e) check("std part", rwire, e);
        end
        rs_n = 1;
    endtask
    initial begin
        {resetn, sel, nar, byt, wq, rq} = '0;
        {ws_n, wd, rs_n, rd} = 4'hF;
        wdata = BMF_DATA_RST;
        for (int c = 0; c < 5; c++) begin
            start(cfg[c][3], cfg[c][2], cfg[c][1], cfg[c][0]);
            check("empty", rst_s, 1'b0);
            wr(1, 50, 1'b1, 1'b1);
            wr(1, 51, 1'b0, 1'b0);
            repeat (6) @(posedge clk);
            #1 check("gated", rst_s, 1'b0);
            ws_n = 0;
            wq = 1;
            wd = 0;
            @(posedge clk);
            #1 check("wr drive", wwire, BMF_DATA_RST);
            check("wr oe", woe, 1'b1);
            ws_n = 1;
            wq = 0;
            wd = 1;
            wr(2, c * 8, 1'b0, 1'b1);
            repeat (8) @(posedge clk);
            #1 check("ae low", ae_n, 1'b0);
            wr(1, c * 8 + 2, 1'b0, 1'b1);
            repeat (8) @(posedge clk);
            #1 check("ae high", ae_n, 1'b1);
            check("af high", af_n, 1'b1);
            for (int i = 0; i < 3; i++) rd_word(f(c * 8 + i));
            repeat (4) @(posedge clk);
            #1 check("drained", rst_s, 1'b0);
        end
        start(1'b1, 1'b1, 1'b0, 1'b0);
        n = 0;
        while (wst === 1'b1 && n < 2100) begin
            wr(1, n, 1'b0, 1'b1);
            n++;
        end
        check("full", wst, 1'b0);
        check("af full", af_n, 1'b0);
        wr(1, 7000, 1'b0, 1'b1);
        for (int i = 0; i < n; i++) rd_word(f(i));
        repeat (8) @(posedge clk);
        #1 check("refused", rst_s, 1'b0);
        check("af clear", af_n, 1'b1);
        results();
    end
    initial begin
        #400000;
        failures++;
        results();
    end
endmodule // bmf_fifo_tb
`default_nettype wire
